//--- qmr_device.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qmr_map.svh"

module qmr_device (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	qmr_if.device            bus,
	input  wire logic        done_valid_in,
	input  wire logic [5:0]  done_queue_in,
	input  wire logic [31:0] done_word_in,
	input  wire logic [13:0] done_size_in,
	output logic             done_ready_out,
	input  wire logic [13:0] link_index_in,
	input  wire logic [31:0] lram0_base_in,
	input  wire logic [31:0] lram1_base_in,
	input  wire logic [13:0] lram0_size_in,
	output logic [31:0]      link_addr_out
);

	// ======================================================================
	// Storage.
	logic [31:0]               node_word_ff [32];
	logic [13:0]               node_size_ff [32];
	qmr_pkg::qmr_node_idx_type node_next_ff [32];
	logic [31:0]               node_free_ff;
	qmr_pkg::qmr_node_idx_type head_ff      [64];
	qmr_pkg::qmr_node_idx_type tail_ff      [64];
	logic [13:0]               count_ff     [64];
	logic [27:0]               bytes_ff     [64];
	logic [63:0]               pend_ff;
	logic [31:0]               rbase_ff     [16];
	logic [31:0]               rctrl_ff     [16];
	logic                      ack_ff;
	logic [31:0]               rdata_ff;
	logic                      done_ready_ff;
	logic [31:0]               link_addr_ff;

	// ======================================================================
	// Helpers.
	function automatic qmr_pkg::qmr_node_idx_type first_free(input logic [31:0] map);
		qmr_pkg::qmr_node_idx_type idx;
		idx = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (map[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction : first_free

	// ======================================================================
	// Access decode.
	logic                      take_done;
	logic                      bus_go;
	logic                      in_queue;
	logic                      in_region;
	qmr_pkg::qmr_queue_idx_type bq;
	logic [3:0]                br;
	logic [1:0]                bsub;
	logic                      push_go;
	logic                      pop_go;
	qmr_pkg::qmr_queue_idx_type push_q;
	logic [31:0]               push_word;
	logic [13:0]               push_size;
	qmr_pkg::qmr_node_idx_type free_idx;
	qmr_pkg::qmr_node_idx_type pop_idx;
	logic [31:0]               rd_val;

	assign take_done = done_valid_in & done_ready_ff;
	assign bus_go    = bus.req & ~ack_ff & ~take_done;
	assign in_queue  = (bus.addr[13:12] == `QMR_QUEUE_PAGE) && (bus.addr[11:10] == 2'h0);
	assign in_region = (bus.addr[13:12] == `QMR_REGION_PAGE) && (bus.addr[11:8] == 4'h0);
	assign bq        = bus.addr[9:4];
	assign br        = bus.addr[7:4];
	assign bsub      = bus.addr[3:2];
	assign free_idx  = first_free(node_free_ff);
	assign pop_idx   = head_ff[bq];

	// A push is dropped when no free node remains.
	assign push_go   = (take_done | (bus_go & bus.wr & in_queue
		&& bsub == `QMR_Q_PUSH_POP_SUB)) & (|node_free_ff);
	assign pop_go    = bus_go & ~bus.wr & in_queue
		&& bsub == `QMR_Q_PUSH_POP_SUB && pend_ff[bq];
	assign push_q    = take_done ? done_queue_in : bq;
	assign push_word = take_done ? done_word_in : bus.wdata;
	assign push_size = take_done ? done_size_in : bus.wsize;

	// ======================================================================
	// Read multiplexer.
	always_comb begin
		rd_val = 32'h00000000;
		if (bus.addr == `QMR_PEND_LOW_ADDR) begin
			rd_val = pend_ff[31:0];
		end else if (bus.addr == `QMR_PEND_HIGH_ADDR) begin
			rd_val = pend_ff[63:32];
		end else if (in_region) begin
			case (bsub)
				`QMR_REGION_BASE_SUB: rd_val = rbase_ff[br];
				`QMR_REGION_CTRL_SUB: rd_val = rctrl_ff[br] & `QMR_REGION_CTRL_MASK;
				default:              rd_val = 32'h00000000;
			endcase
		end else if (in_queue) begin
			case (bsub)
				`QMR_Q_PUSH_POP_SUB: rd_val = pend_ff[bq] ? node_word_ff[pop_idx] : 32'h00000000;
				`QMR_Q_ENTRY_SUB:    rd_val = {18'h00000, count_ff[bq]};
				`QMR_Q_BYTE_SUB:     rd_val = {4'h0, bytes_ff[bq]};
				`QMR_Q_HEAD_SUB:     rd_val = pend_ff[bq] ? {18'h00000, node_size_ff[pop_idx]} : 32'h00000000;
				default:             rd_val = 32'h00000000;
			endcase
		end
	end

	// ======================================================================
	// Node storage and links, data only.
	always_ff @(posedge ref_clk_in) begin
		if (push_go) begin
			node_word_ff[free_idx] <= push_word;
			node_size_ff[free_idx] <= push_size;
			if (pend_ff[push_q]) begin
				node_next_ff[tail_ff[push_q]] <= free_idx;
			end
		end
	end

	// ======================================================================
	// Free node map.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			node_free_ff <= 32'hFFFFFFFF;
		end else if (push_go) begin
			node_free_ff[free_idx] <= 1'b0;
		end else if (pop_go) begin
			node_free_ff[pop_idx] <= 1'b1;
		end
	end

	// ======================================================================
	// Queue heads, tails, counts and pending flags.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 64; i++) begin
				head_ff[i]  <= 5'h00;
				tail_ff[i]  <= 5'h00;
				count_ff[i] <= 14'h0000;
				bytes_ff[i] <= 28'h0000000;
			end
			pend_ff <= 64'h0000000000000000;
		end else if (push_go) begin
			if (!pend_ff[push_q]) begin
				head_ff[push_q] <= free_idx;
			end
			tail_ff[push_q]  <= free_idx;
			count_ff[push_q] <= count_ff[push_q] + 14'h0001;
			bytes_ff[push_q] <= bytes_ff[push_q] + {14'h0000, push_size};
			pend_ff[push_q]  <= 1'b1;
		end else if (pop_go) begin
			head_ff[bq]  <= node_next_ff[pop_idx];
			count_ff[bq] <= count_ff[bq] - 14'h0001;
			bytes_ff[bq] <= bytes_ff[bq] - {14'h0000, node_size_ff[pop_idx]};
			if (count_ff[bq] == 14'h0001) begin
				pend_ff[bq] <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Memory region registers.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 16; i++) begin
				rbase_ff[i] <= `QMR_REGION_BASE_RST;
				rctrl_ff[i] <= `QMR_REGION_CTRL_RST;
			end
		end else if (bus_go && bus.wr && in_region) begin
			if (bsub == `QMR_REGION_BASE_SUB) begin
				rbase_ff[br] <= bus.wdata;
			end else if (bsub == `QMR_REGION_CTRL_SUB) begin
				rctrl_ff[br] <= bus.wdata & `QMR_REGION_CTRL_MASK;
			end
		end
	end

	// ======================================================================
	// Port answer: one acknowledge the cycle after a request is taken.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else begin
			ack_ff <= bus_go;
			if (bus_go && !bus.wr) begin
				rdata_ff <= rd_val;
			end
		end
	end

	// ======================================================================
	// Completion feed: ready drops for one cycle after each accept so a
	// waiting port access is never starved.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_ready_ff <= 1'b0;
		end else begin
			done_ready_ff <= ~take_done;
		end
	end

	// ======================================================================
	// Linking address of a descriptor index.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			link_addr_ff <= 32'h00000000;
		end else if (link_index_in < lram0_size_in) begin
			link_addr_ff <= lram0_base_in + {16'h0000, link_index_in, 2'h0};
		end else begin
			link_addr_ff <= lram1_base_in + {16'h0000, link_index_in, 2'h0};
		end
	end

	assign bus.ack        = ack_ff;
	assign bus.rdata      = rdata_ff;
	assign done_ready_out = done_ready_ff;
	assign link_addr_out  = link_addr_ff;

endmodule : qmr_device

`default_nettype wire

//--- qmr_map.svh
`ifndef QMR_MAP_SVH
`define QMR_MAP_SVH

// ==========================================================================
// Device register map, byte addresses on the device port.
`define QMR_PEND_LOW_ADDR    14'h0090
`define QMR_PEND_HIGH_ADDR   14'h0094
`define QMR_REGION_PAGE      2'h1
`define QMR_QUEUE_PAGE       2'h2
`define QMR_REGION_BASE_SUB  2'h0
`define QMR_REGION_CTRL_SUB  2'h1
`define QMR_Q_PUSH_POP_SUB   2'h0
`define QMR_Q_ENTRY_SUB      2'h1
`define QMR_Q_BYTE_SUB       2'h2
`define QMR_Q_HEAD_SUB       2'h3

// ==========================================================================
// Region control layout.
`define QMR_REGION_CTRL_MASK 32'h3FFF0F07
`define QMR_REGION_CTRL_RST  32'h00000000
`define QMR_REGION_BASE_RST  32'h00000000

// ==========================================================================
// Status field masks.
`define QMR_ENTRY_MASK       32'h00003FFF
`define QMR_BYTE_MASK        32'h0FFFFFFF

// ==========================================================================
// Controller register map, byte addresses on APB.
`define QMR_H_CMD_ADDR       12'h000
`define QMR_H_WDATA_ADDR     12'h004
`define QMR_H_SIZE_ADDR      12'h008
`define QMR_H_RDATA_ADDR     12'h00C
`define QMR_H_STATUS_ADDR    12'h010
`define QMR_H_CMD_WR_BIT     31

`endif

//--- qmr_pkg.sv
`default_nettype none

package qmr_pkg;
	typedef enum logic {
		QMR_H_IDLE,
		QMR_H_WAIT
	} qmr_hstate_type;

	typedef logic [4:0] qmr_node_idx_type;
	typedef logic [5:0] qmr_queue_idx_type;
endpackage : qmr_pkg

`default_nettype wire

//--- qmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface qmr_if;
	logic        req;
	logic        wr;
	logic [13:0] addr;
	logic [31:0] wdata;
	logic [13:0] wsize;
	logic [31:0] rdata;
	logic        ack;

	modport device (
		input  req,
		input  wr,
		input  addr,
		input  wdata,
		input  wsize,
		output rdata,
		output ack
	);

	modport host (
		output req,
		output wr,
		output addr,
		output wdata,
		output wsize,
		input  rdata,
		input  ack
	);
endinterface : qmr_if

`default_nettype wire

//--- qmr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "qmr_map.svh"

module qmr_host (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	qmr_if.host              bus,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	// ======================================================================
	// State.
	qmr_pkg::qmr_hstate_type state_ff;
	logic                    req_ff;
	logic                    wr_ff;
	logic [13:0]             addr_ff;
	logic [31:0]             wdata_ff;
	logic [13:0]             wsize_ff;
	logic [31:0]             result_ff;
	logic [31:0]             prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic                    apb_done;
	logic                    mapped;
	logic [31:0]             rd_val;

	assign apb_done = psel & penable & pready_ff;
	assign mapped   = (paddr == `QMR_H_CMD_ADDR) || (paddr == `QMR_H_WDATA_ADDR)
		|| (paddr == `QMR_H_SIZE_ADDR) || (paddr == `QMR_H_RDATA_ADDR)
		|| (paddr == `QMR_H_STATUS_ADDR);

	always_comb begin
		case (paddr)
			`QMR_H_CMD_ADDR:    rd_val = {wr_ff, 17'h00000, addr_ff};
			`QMR_H_WDATA_ADDR:  rd_val = wdata_ff;
			`QMR_H_SIZE_ADDR:   rd_val = {18'h00000, wsize_ff};
			`QMR_H_RDATA_ADDR:  rd_val = result_ff;
			`QMR_H_STATUS_ADDR: rd_val = {31'h00000000, state_ff == qmr_pkg::QMR_H_WAIT};
			default:            rd_val = 32'h00000000;
		endcase
	end

	// ======================================================================
	// APB slave: one wait state per access.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= rd_val;
			end
		end
	end

	// ======================================================================
	// Order registers and the device port sequencer.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff  <= qmr_pkg::QMR_H_IDLE;
			req_ff    <= 1'b0;
			wr_ff     <= 1'b0;
			addr_ff   <= 14'h0000;
			wdata_ff  <= 32'h00000000;
			wsize_ff  <= 14'h0000;
			result_ff <= 32'h00000000;
		end else begin
			case (state_ff)
				qmr_pkg::QMR_H_IDLE: begin
					if (apb_done && pwrite) begin
						if (paddr == `QMR_H_WDATA_ADDR) begin
							wdata_ff <= pwdata;
						end else if (paddr == `QMR_H_SIZE_ADDR) begin
							wsize_ff <= pwdata[13:0];
						end else if (paddr == `QMR_H_CMD_ADDR) begin
							wr_ff    <= pwdata[`QMR_H_CMD_WR_BIT];
							addr_ff  <= {pwdata[13:2], 2'h0};
							req_ff   <= 1'b1;
							state_ff <= qmr_pkg::QMR_H_WAIT;
						end
					end
				end
				qmr_pkg::QMR_H_WAIT: begin
					if (bus.ack) begin
						req_ff   <= 1'b0;
						state_ff <= qmr_pkg::QMR_H_IDLE;
						if (!wr_ff) begin
							result_ff <= bus.rdata;
						end
					end
				end
				default: begin
					req_ff   <= 1'b0;
					state_ff <= qmr_pkg::QMR_H_IDLE;
				end
			endcase
		end
	end

	assign bus.req   = req_ff;
	assign bus.wr    = wr_ff;
	assign bus.addr  = addr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.wsize = wsize_ff;
	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;

endmodule : qmr_host

`default_nettype wire

//--- qmr_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Watches the device port between the host sequencer and the queue device.
module qmr_checker (
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	input wire logic        req,
	input wire logic        wr,
	input wire logic [13:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [13:0] wsize,
	input wire logic [31:0] rdata,
	input wire logic        ack
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	ack_cause_a: assert property (ack |-> req && $past(req))
		else $error("ack without a pending request");
	req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wr)
		&& $stable(wdata) && $stable(wsize))
		else $error("request changed before ack");
	req_drop_a: assert property (ack |=> !req)
		else $error("request not dropped after ack");
	ack_bound_a: assert property ($rose(req) |-> ##[1:8] ack)
		else $error("no ack within eight cycles");
	addr_align_a: assert property (req |-> addr[1:0] == 2'h0)
		else $error("unaligned word address");
	rdata_hold_a: assert property ($changed(rdata) |-> ack && !wr)
		else $error("read data moved outside a read answer");
	req_space_a: assert property ($fell(req) |-> !ack ##1 1'b1)
		else $error("ack seen after request dropped");

	cover property (ack && wr);
	cover property (ack && !wr && rdata != 32'h0);
	cover property (ack && !wr && rdata == 32'h0);
endmodule : qmr_checker

`default_nettype wire

//--- descriptor_queue_manager_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qmr_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end

module descriptor_queue_manager_regs_tb;
	logic        ref_clk_in;
	logic        rst_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        done_valid_in;
	logic [5:0]  done_queue_in;
	logic [31:0] done_word_in;
	logic [13:0] done_size_in;
	logic        done_ready_out;
	logic [13:0] link_index_in;
	logic [31:0] lram0_base_in;
	logic [31:0] lram1_base_in;
	logic [13:0] lram0_size_in;
	logic [31:0] link_addr_out;
	logic [31:0] rd;
	logic        er;
	int          num_errors;
	int          compares;
	int          cyc;

	qmr_if bus ();
	qmr_device qmr_device_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(bus),
		.done_valid_in(done_valid_in), .done_queue_in(done_queue_in),
		.done_word_in(done_word_in), .done_size_in(done_size_in),
		.done_ready_out(done_ready_out), .link_index_in(link_index_in),
		.lram0_base_in(lram0_base_in), .lram1_base_in(lram1_base_in),
		.lram0_size_in(lram0_size_in), .link_addr_out(link_addr_out));
	qmr_host qmr_host_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(bus),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	qmr_checker qmr_checker_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.req(bus.req), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata),
		.wsize(bus.wsize), .rdata(bus.rdata), .ack(bus.ack));

	always #12.5 ref_clk_in = ~ref_clk_in;

	// ======================================================================
	// Bus helpers.
	function automatic logic [13:0] qa(input int n, input int s);
		return 14'h2000 + 14'(n * 16 + s * 4);
	endfunction : qa

	function automatic logic [13:0] ra(input int n, input int s);
		return 14'h1000 + 14'(n * 16 + s * 4);
	endfunction : ra

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		do @(posedge ref_clk_in); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic dev(input logic w, input logic [13:0] a, input logic [31:0] d,
		input logic [13:0] s);
		apb(1'b1, `QMR_H_WDATA_ADDR, d);
		apb(1'b1, `QMR_H_SIZE_ADDR, {18'h0, s});
		apb(1'b1, `QMR_H_CMD_ADDR, {w, 17'h0, a});
		rd = 32'h1;
		while (rd[0] !== 1'b0) apb(1'b0, `QMR_H_STATUS_ADDR, 32'h0);
		apb(1'b0, `QMR_H_RDATA_ADDR, 32'h0);
	endtask : dev

	task automatic rdchk(input string n, input logic [13:0] a, input logic [31:0] e);
		dev(1'b0, a, 32'h0, 14'h0);
		`CHK(n, e, rd)
	endtask : rdchk

	// ======================================================================
	// Scenarios.
	task automatic t_push_pop();
		rdchk("pend_low_rst", `QMR_PEND_LOW_ADDR, 32'h0);
		dev(1'b1, qa(5, 0), 32'hA000_0021, 14'h0040);
		dev(1'b1, qa(5, 0), 32'hB000_0042, 14'h0100);
		dev(1'b1, qa(40, 0), 32'hC000_0003, 14'h0010);
		rdchk("pend_low", `QMR_PEND_LOW_ADDR, 32'h0000_0020);
		rdchk("pend_high", `QMR_PEND_HIGH_ADDR, 32'h0000_0100);
		rdchk("entry", qa(5, 1), 32'h2);
		rdchk("bytes", qa(5, 2), 32'h140);
		rdchk("head", qa(5, 3), 32'h40);
		rdchk("pop1", qa(5, 0), 32'hA000_0021);
		rdchk("head2", qa(5, 3), 32'h100);
		rdchk("bytes2", qa(5, 2), 32'h100);
		rdchk("pop2", qa(5, 0), 32'hB000_0042);
		rdchk("pend_clr", `QMR_PEND_LOW_ADDR, 32'h0);
		rdchk("pop_empty", qa(5, 0), 32'h0);
		rdchk("entry0", qa(5, 1), 32'h0);
		rdchk("pop40", qa(40, 0), 32'hC000_0003);
		rdchk("pend_hclr", `QMR_PEND_HIGH_ADDR, 32'h0);
	endtask : t_push_pop

	task automatic t_region();
		logic [31:0] v;
		for (int c = 0; c < 16; c++) begin
			v = {2'h3, 14'h3FFF - 14'(c), 4'hF, 4'(c), 5'h1F, 3'(c)};
			dev(1'b1, ra(c, 0), 32'h5A5A_0000 + 32'(c), 14'h0);
			dev(1'b1, ra(c, 1), v, 14'h0);
		end
		for (int c = 0; c < 16; c++) begin
			v = {2'h3, 14'h3FFF - 14'(c), 4'hF, 4'(c), 5'h1F, 3'(c)};
			rdchk("base", ra(c, 0), 32'h5A5A_0000 + 32'(c));
			rdchk("ctrl", ra(c, 1), v & 32'h3FFF_0F07);
		end
	endtask : t_region

	task automatic t_completion();
		@(posedge ref_clk_in);
		done_valid_in <= 1'b1;
		done_queue_in <= 6'h3F;
		done_word_in  <= 32'hD000_0045;
		done_size_in  <= 14'h0200;
		do @(posedge ref_clk_in); while (done_ready_out !== 1'b1);
		done_valid_in <= 1'b0;
		rdchk("pend_done", `QMR_PEND_HIGH_ADDR, 32'h8000_0000);
		rdchk("pop_done", qa(63, 0), 32'hD000_0045);
	endtask : t_completion

	// ======================================================================
	// Fills the whole node pool; the push beyond it must be dropped.
	task automatic t_pool();
		for (int i = 0; i < 33; i++) begin
			dev(1'b1, qa(9, 0), 32'h0100_0000 + 32'(i * 32), 14'h0004);
		end
		rdchk("pool_entry", qa(9, 1), 32'h20);
		rdchk("pool_bytes", qa(9, 2), 32'h80);
		for (int i = 0; i < 32; i++) begin
			rdchk("pool_pop", qa(9, 0), 32'h0100_0000 + 32'(i * 32));
		end
		rdchk("pool_empty", qa(9, 0), 32'h0);
		rdchk("pool_pend", `QMR_PEND_LOW_ADDR, 32'h0);
	endtask : t_pool

	task automatic t_link();
		lram0_base_in <= 32'h1000_0000;
		lram1_base_in <= 32'h2000_0000;
		lram0_size_in <= 14'h0064;
		link_index_in <= 14'h0063;
		repeat (2) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		`CHK("link0", 32'h1000_018C, link_addr_out)
		@(posedge ref_clk_in);
		link_index_in <= 14'h0064;
		repeat (2) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		`CHK("link1", 32'h2000_0190, link_addr_out)
	endtask : t_link

	task automatic t_unmapped();
		apb(1'b0, 12'h020, 32'h0);
		`CHK("apb_err", 1'b1, er)
		rdchk("dev_hole", 14'h3000, 32'h0);
	endtask : t_unmapped

	task automatic results();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		{ref_clk_in, psel, penable, pwrite, done_valid_in} = '0;
		{paddr, pwdata, done_queue_in, done_word_in, done_size_in} = '0;
		{link_index_in, lram0_base_in, lram1_base_in, lram0_size_in} = '0;
		{num_errors, compares, cyc} = '0;
		rst_in = 1'b1;
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_push_pop();
		t_region();
		t_completion();
		t_pool();
		t_link();
		t_unmapped();
		results();
	end
endmodule : descriptor_queue_manager_regs_tb

`default_nettype wire
